// *** core/byte_rotate_unit.sv ***
`timescale 1ns/100ps

// Summary of operation
// - Rotate left to working register: bit 7 to bit 0, memory and flags kept.
// - Rotate left through carry in place: old carry to bit 0, bit 7 to carry.
// - Rotate left through carry to working register, carry from bit 7, memory kept.
// - Rotate right in place: bit 0 to bit 7, written back, no flag changed.
// - Rotate right to working register: bit 0 to bit 7, memory and flags kept.
// - Rotate right through carry in place: old carry to bit 7, bit 0 to carry.
module byte_rotate_unit
(
	input  wire logic                 clk,        // Core clock
	input  wire logic                 rst_n,      // Synchronous reset, active low
	input  wire logic                 op_valid,   // Execute the selected operation this cycle
	input  wire rotate_pkg::rot_op_t  op_sel,     // Operation select
	input  wire logic [7:0]           mem_rdata,  // Data memory operand
	output logic      [7:0]           mem_wdata,  // Byte to write back
	output logic                      mem_we,     // Memory write strobe
	output logic      [7:0]           working_register, // Working register
	output logic                      carry       // Carry flag
);

	////////////////////////////////////////////////////////////////////////
	// Decode

	wire logic is_rotl_wreg       = op_sel == rotate_pkg::op_rotl_into_working_reg;
	wire logic is_rotl_carry_mem  = op_sel == rotate_pkg::op_rotate_left_via_carry_in_place;
	wire logic is_rotl_carry_wreg = op_sel == rotate_pkg::op_rotate_left_via_carry_to_working_reg;
	wire logic is_rotr_mem        = op_sel == rotate_pkg::op_rotate_right_in_place;
	wire logic is_rotr_wreg       = op_sel == rotate_pkg::op_rotate_right_to_working_reg;
	wire logic is_rotr_carry_mem  = op_sel == rotate_pkg::op_rotate_right_via_carry_in_place;

	wire logic go_left   = is_rotl_wreg | is_rotl_carry_mem | is_rotl_carry_wreg;
	wire logic via_carry = is_rotl_carry_mem | is_rotl_carry_wreg | is_rotr_carry_mem;
	wire logic to_mem    = is_rotl_carry_mem | is_rotr_mem | is_rotr_carry_mem;
	wire logic to_wreg   = is_rotl_wreg | is_rotl_carry_wreg | is_rotr_wreg;

	////////////////////////////////////////////////////////////////////////
	// Datapath

	logic [7:0] rotated;
	logic       out_bit;
	logic [7:0] wreg_q;
	logic       carry_q;
	logic [7:0] wdata_q;
	logic       we_q;

	// Plain rotate refills with the bit leaving the far end
	wire logic fill_bit = via_carry ? carry_q
		: (go_left ? mem_rdata[rotate_pkg::MSB] : mem_rdata[rotate_pkg::LSB]);

	rotate_shifter u_shift
	(
		.operand  (mem_rdata),
		.go_left  (go_left),
		.fill_bit (fill_bit),
		.rotated  (rotated),
		.out_bit  (out_bit)
	);

	wire logic       wreg_load  = op_valid & to_wreg;
	wire logic       mem_store  = op_valid & to_mem;
	wire logic       carry_load = op_valid & via_carry;
	wire logic [7:0] wreg_d     = wreg_load ? rotated : wreg_q;
	wire logic       carry_d    = carry_load ? out_bit : carry_q;

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			wreg_q  <= rotate_pkg::WREG_RESET;
			carry_q <= rotate_pkg::CARRY_RESET;
			wdata_q <= rotate_pkg::WDATA_RESET;
			we_q    <= 1'b0;
		end
		else
		begin
			wreg_q  <= wreg_d;
			carry_q <= carry_d;
			we_q    <= mem_store;
			if (mem_store)
				wdata_q <= rotated;
		end
	end

	// Write-back is registered, one cycle after the operation
	assign mem_wdata        = wdata_q;
	assign mem_we           = we_q;
	assign working_register = wreg_q;
	assign carry            = carry_q;

	////////////////////////////////////////////////////////////////////////
	// Checks

	// Every check spans one edge, with |=> or $past: outputs are registered, so an
	// operation taken at one edge shows at the next

	rotl_wreg_a: assert property (@(posedge clk) disable iff (!rst_n)
		op_valid && is_rotl_wreg
		|=> wreg_q == {$past(mem_rdata[6:0]), $past(mem_rdata[7])}
		&& !we_q
		&& $stable(carry_q))
		else $error("rotate left to working register wrong");

	rotl_carry_mem_a: assert property (@(posedge clk) disable iff (!rst_n)
		op_valid && is_rotl_carry_mem
		|=> we_q
		&& wdata_q == {$past(mem_rdata[6:0]), $past(carry_q)}
		&& carry_q == $past(mem_rdata[7])
		&& $stable(wreg_q))
		else $error("rotate left through carry in place wrong");

	rotl_carry_wreg_a: assert property (@(posedge clk) disable iff (!rst_n)
		op_valid && is_rotl_carry_wreg
		|=> !we_q
		&& wreg_q == {$past(mem_rdata[6:0]), $past(carry_q)}
		&& carry_q == $past(mem_rdata[7]))
		else $error("rotate left through carry to working register wrong");

	rotr_mem_a: assert property (@(posedge clk) disable iff (!rst_n)
		op_valid && is_rotr_mem
		|=> we_q
		&& wdata_q == {$past(mem_rdata[0]), $past(mem_rdata[7:1])}
		&& $stable(carry_q)
		&& $stable(wreg_q))
		else $error("rotate right in place wrong");

	rotr_wreg_a: assert property (@(posedge clk) disable iff (!rst_n)
		op_valid && is_rotr_wreg
		|=> wreg_q == {$past(mem_rdata[0]), $past(mem_rdata[7:1])}
		&& !we_q
		&& $stable(carry_q))
		else $error("rotate right to working register wrong");

	rotr_carry_mem_a: assert property (@(posedge clk) disable iff (!rst_n)
		op_valid && is_rotr_carry_mem
		|=> we_q
		&& wdata_q == {$past(carry_q), $past(mem_rdata[7:1])}
		&& carry_q == $past(mem_rdata[0]))
		else $error("rotate right through carry in place wrong");

	// Carry 0 with 80 going left: a carry taken after its own update would land in bit 0
	carry_same_a: assert property (@(posedge clk) disable iff (!rst_n)
		op_valid && via_carry && go_left && mem_rdata == 8'h80 && !carry_q
		|=> carry_q
		&& (we_q ? wdata_q : wreg_q) == 8'h00)
		else $error("carry update not from old values");

	// Same hazard going right: 01 with carry 0 must give 00 and carry 1
	carry_right_same_a: assert property (@(posedge clk) disable iff (!rst_n)
		op_valid && is_rotr_carry_mem && mem_rdata == 8'h01 && !carry_q
		|=> carry_q
		&& wdata_q == 8'h00)
		else $error("right carry update not from old values");

	idle_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
		!op_valid
		|=> !we_q
		&& $stable(carry_q)
		&& $stable(wreg_q))
		else $error("state changed without an operation");

	// A select with no operation behind it must not disturb anything
	none_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
		op_valid && op_sel == rotate_pkg::op_none
		|=> !we_q
		&& $stable(carry_q)
		&& $stable(wreg_q))
		else $error("empty select changed state");

	plain_carry_keep_a: assert property (@(posedge clk) disable iff (!rst_n)
		op_valid && !via_carry
		|=> $stable(carry_q))
		else $error("plain rotate changed carry");

	// Write-back data stays for the memory side until the next in-place op
	wdata_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
		!(op_valid && to_mem)
		|=> $stable(wdata_q))
		else $error("write-back data changed without an in-place op");

	inplace_wreg_keep_a: assert property (@(posedge clk) disable iff (!rst_n)
		op_valid && to_mem
		|=> $stable(wreg_q))
		else $error("in-place op changed working register");

	// The first edge after reset compares against reset values, so it is skipped
	carry_cause_a: assert property (@(posedge clk) disable iff (!rst_n)
		$past(rst_n) && $changed(carry_q)
		|-> $past(op_valid) && $past(via_carry))
		else $error("carry changed without a through-carry op");

	wreg_cause_a: assert property (@(posedge clk) disable iff (!rst_n)
		$past(rst_n) && $changed(wreg_q)
		|-> $past(op_valid) && $past(to_wreg))
		else $error("working register changed without a load");

	////////////////////////////////////////////////////////////////////////
	// Per-bit checks

	// Bits 0 to 6 going left, 1 to 7 going right, move one place; the wrapped end bit is checked above
	for (genvar i = 0; i < rotate_pkg::MSB; i++)
	begin : g_bit_check
		left_wreg_bit_a: assert property (@(posedge clk) disable iff (!rst_n)
			op_valid && go_left && to_wreg
			|=> wreg_q[i + 1] == $past(mem_rdata[i]))
			else $error("left rotate bit to working register wrong");

		left_mem_bit_a: assert property (@(posedge clk) disable iff (!rst_n)
			op_valid && go_left && to_mem
			|=> wdata_q[i + 1] == $past(mem_rdata[i]))
			else $error("left rotate bit to write-back wrong");

		right_wreg_bit_a: assert property (@(posedge clk) disable iff (!rst_n)
			op_valid && !go_left && to_wreg
			|=> wreg_q[i] == $past(mem_rdata[i + 1]))
			else $error("right rotate bit to working register wrong");

		right_mem_bit_a: assert property (@(posedge clk) disable iff (!rst_n)
			op_valid && !go_left && to_mem
			|=> wdata_q[i] == $past(mem_rdata[i + 1]))
			else $error("right rotate bit to write-back wrong");
	end

endmodule : byte_rotate_unit

// *** core/rotate_shifter.sv ***
`timescale 1ns/100ps

// Pure combinational one-bit rotator; fill bit chooses plain or through-carry
module rotate_shifter
(
	input  wire logic [7:0] operand,   // Byte to rotate
	input  wire logic       go_left,   // 1 left, 0 right
	input  wire logic       fill_bit,  // Bit shifted into the vacated end
	output logic      [7:0] rotated,   // Rotated byte
	output logic            out_bit    // Bit shifted out of the far end
);

	assign rotated = go_left ? {operand[6:0], fill_bit} : {fill_bit, operand[7:1]};
	assign out_bit = go_left ? operand[rotate_pkg::MSB] : operand[rotate_pkg::LSB];

endmodule : rotate_shifter

// *** shared/rotate_pkg.sv ***
package rotate_pkg;

	localparam int DATA_W = 8;
	localparam int MSB    = 7;
	localparam int LSB    = 0;

	localparam logic [7:0] WREG_RESET  = 8'h00;
	localparam logic       CARRY_RESET = 1'b0;
	localparam logic [7:0] WDATA_RESET = 8'h00;

	// Operation select from the instruction decoder
	typedef enum logic [2:0]
	{
		op_none,
		op_rotl_into_working_reg,
		op_rotate_left_via_carry_in_place,
		op_rotate_left_via_carry_to_working_reg,
		op_rotate_right_in_place,
		op_rotate_right_to_working_reg,
		op_rotate_right_via_carry_in_place
	} rot_op_t;

endpackage : rotate_pkg

// *** testbench/tb.sv ***
`timescale 1ns/100ps

module tb;
	logic                clk;
	logic                rst_n;
	logic                op_valid;
	rotate_pkg::rot_op_t op_sel;
	logic [7:0]          mem_rdata;
	logic [7:0]          mem_wdata;
	logic                mem_we;
	logic [7:0]          working_register;
	logic                carry;
	int                  fail_count;
	int                  checked;

	byte_rotate_unit DUT (.clk(clk), .rst_n(rst_n), .op_valid(op_valid), .op_sel(op_sel), .mem_rdata(mem_rdata),
		.mem_wdata(mem_wdata), .mem_we(mem_we), .working_register(working_register), .carry(carry));

	initial
	begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	////////////////////////////////////////////////////////////////
	task check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		checked++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task expect4(input logic [7:0] w, input logic c, input logic we, input logic [7:0] m);
		check("working_register", working_register, w);
		check("carry", {7'h00, carry}, {7'h00, c});
		check("mem_we", {7'h00, mem_we}, {7'h00, we});
		check("mem_wdata", mem_wdata, m);
	endtask : expect4

	// Holds inputs after the edge so back-to-back ops never glitch op_valid
	task run_op(input rotate_pkg::rot_op_t op, input logic v, input logic [7:0] d);
		op_sel = op;
		op_valid = v;
		mem_rdata = d;
		@(posedge clk);
		#1;
	endtask : run_op

	////////////////////////////////////////////////////////////////
	task test_carry;
		run_op(rotate_pkg::op_rotate_left_via_carry_in_place, 1'b1, 8'h80);
		expect4(8'h00, 1'b1, 1'b1, 8'h00);
		run_op(rotate_pkg::op_rotate_left_via_carry_to_working_reg, 1'b1, 8'h40);
		expect4(8'h81, 1'b0, 1'b0, 8'h00);
		run_op(rotate_pkg::op_rotate_right_via_carry_in_place, 1'b1, 8'h03);
		expect4(8'h81, 1'b1, 1'b1, 8'h01);
		run_op(rotate_pkg::op_rotate_right_via_carry_in_place, 1'b1, 8'h02);
		expect4(8'h81, 1'b0, 1'b1, 8'h81);
		run_op(rotate_pkg::op_rotate_left_via_carry_to_working_reg, 1'b1, 8'hff);
		expect4(8'hfe, 1'b1, 1'b0, 8'h81);
		$display("test_carry done");
	endtask : test_carry

	// Carry is 1 here, so a plain rotate that leaks carry shows
	task test_wreg;
		run_op(rotate_pkg::op_rotl_into_working_reg, 1'b1, 8'h40);
		expect4(8'h80, 1'b1, 1'b0, 8'h81);
		run_op(rotate_pkg::op_rotate_right_to_working_reg, 1'b1, 8'h02);
		expect4(8'h01, 1'b1, 1'b0, 8'h81);
		$display("test_wreg done");
	endtask : test_wreg

	task test_in_place;
		run_op(rotate_pkg::op_rotate_right_in_place, 1'b1, 8'h01);
		expect4(8'h01, 1'b1, 1'b1, 8'h80);
		run_op(rotate_pkg::op_rotate_right_in_place, 1'b1, 8'h02);
		expect4(8'h01, 1'b1, 1'b1, 8'h01);
		$display("test_in_place done");
	endtask : test_in_place

	task test_refused;
		run_op(rotate_pkg::op_none, 1'b1, 8'hff);
		expect4(8'h01, 1'b1, 1'b0, 8'h01);
		run_op(rotate_pkg::op_rotl_into_working_reg, 1'b0, 8'h55);
		expect4(8'h01, 1'b1, 1'b0, 8'h01);
		$display("test_refused done");
	endtask : test_refused

	// Reset must beat an operation presented in the same cycle; state is non-zero here
	task test_reset;
		rst_n = 1'b0;
		run_op(rotate_pkg::op_rotate_left_via_carry_in_place, 1'b1, 8'hff);
		run_op(rotate_pkg::op_rotate_left_via_carry_in_place, 1'b1, 8'hff);
		expect4(rotate_pkg::WREG_RESET, rotate_pkg::CARRY_RESET, 1'b0, rotate_pkg::WDATA_RESET);
		rst_n = 1'b1;
		run_op(rotate_pkg::op_none, 1'b0, 8'h00);
		expect4(rotate_pkg::WREG_RESET, rotate_pkg::CARRY_RESET, 1'b0, rotate_pkg::WDATA_RESET);
		run_op(rotate_pkg::op_rotate_right_via_carry_in_place, 1'b1, 8'h01);
		expect4(rotate_pkg::WREG_RESET, 1'b1, 1'b1, 8'h00);
		$display("test_reset done");
	endtask : test_reset

	task final_report;
		$display("checks %0d mismatches %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : final_report

	initial
	begin
		fail_count = 0;
		checked = 0;
		rst_n = 1'b0;
		op_valid = 1'b0;
		op_sel = rotate_pkg::op_none;
		mem_rdata = 8'h00;
		repeat (2) @(posedge clk);
		#1;
		rst_n = 1'b1;
		expect4(8'h00, 1'b0, 1'b0, 8'h00);
		run_op(rotate_pkg::op_none, 1'b0, 8'h00);
		test_carry();
		test_wreg();
		test_in_place();
		test_refused();
		test_reset();
		final_report();
	end
endmodule : tb
